//--- rtl/readback_pkg.sv
// Shared constants and types for the motor measurement readback register bank
package readback_pkg;

  // ----------------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 13;
  localparam int IDX_W  = 11;
  localparam int CODE_W = 16;

  // ----------------------------------------------------------------------------
  // Register indices as printed; byte address is four times the index
  // ----------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PULSE_SPEED   = 11'h196;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_CUR    = 11'h410;
  localparam logic [IDX_W-1:0] IDX_PHASE_ONE     = 11'h440;
  localparam logic [IDX_W-1:0] IDX_PHASE_TWO     = 11'h442;
  localparam logic [IDX_W-1:0] IDX_PHASE_THREE   = 11'h444;
  localparam logic [IDX_W-1:0] IDX_GAIN_CODE     = 11'h468;
  localparam logic [IDX_W-1:0] IDX_RANGE_CODE    = 11'h472;

  localparam logic [ADDR_W-1:0] ADDR_PULSE_SPEED = {IDX_PULSE_SPEED, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_CUR  = {IDX_SUPPLY_CUR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PHASE_ONE   = {IDX_PHASE_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PHASE_TWO   = {IDX_PHASE_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PHASE_THREE = {IDX_PHASE_THREE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GAIN_CODE   = {IDX_GAIN_CODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RANGE_CODE  = {IDX_RANGE_CODE, 2'b00};

  // ----------------------------------------------------------------------------
  // Storage slots: five wide measurement words, then two code words
  // ----------------------------------------------------------------------------
  localparam int NUM_SLOTS = 7;
  localparam int NUM_WIDE  = 5;
  localparam int SLOT_W    = 3;
  localparam logic [SLOT_W-1:0] SLOT_PULSE_SPEED = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_SUPPLY_CUR  = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_PHASE_ONE   = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_PHASE_TWO   = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_PHASE_THREE = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_GAIN_CODE   = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_RANGE_CODE  = 3'h6;

  // ----------------------------------------------------------------------------
  // Reset values and code encodings
  // ----------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_WIDE  = 32'h0000_0000;
  localparam logic [CODE_W-1:0] RST_CODE  = 16'h0000;
  localparam logic [CODE_W-1:0] GAIN_X8   = 16'h0000;
  localparam logic [CODE_W-1:0] GAIN_X4   = 16'h0001;
  localparam logic [CODE_W-1:0] GAIN_X2   = 16'h0002;
  localparam logic [CODE_W-1:0] GAIN_X1   = 16'h0003;
  localparam logic [CODE_W-1:0] RANGE_60V = 16'h0000;
  localparam logic [CODE_W-1:0] RANGE_30V = 16'h0001;
  localparam logic [CODE_W-1:0] RANGE_15V = 16'h0002;

  // ----------------------------------------------------------------------------
  // Bus responses and handshake states
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {WR_COLLECT, WR_RESP} wr_state_type;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} rd_state_type;

endpackage

//--- rtl/slot_lookup_if.sv
// Address-to-slot lookup carrier between the bus front end and its decoder
`timescale 1ns/1ps
`default_nettype none
interface slot_lookup_if;
  import readback_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              hit;
  logic [SLOT_W-1:0] slot;
  modport requester (output addr, input hit, slot);
  modport decoder   (input addr, output hit, slot);
endinterface
`default_nettype wire

//--- rtl/slot_decode.sv
// Byte address decoder mapping the readback word addresses onto storage slots
`timescale 1ns/1ps
`default_nettype none
module slot_decode (
  // Lookup carrier
  slot_lookup_if.decoder lk
);
  import readback_pkg::*;

  // ----------------------------------------------------------------------------
  // Decode; low address bits take part, so a misaligned address misses
  // ----------------------------------------------------------------------------
  always_comb begin
    lk.hit  = 1'b1;
    lk.slot = SLOT_PULSE_SPEED;
    case (lk.addr)
      ADDR_PULSE_SPEED: lk.slot = SLOT_PULSE_SPEED;
      ADDR_SUPPLY_CUR:  lk.slot = SLOT_SUPPLY_CUR;
      ADDR_PHASE_ONE:   lk.slot = SLOT_PHASE_ONE;
      ADDR_PHASE_TWO:   lk.slot = SLOT_PHASE_TWO;
      ADDR_PHASE_THREE: lk.slot = SLOT_PHASE_THREE;
      ADDR_GAIN_CODE:   lk.slot = SLOT_GAIN_CODE;
      ADDR_RANGE_CODE:  lk.slot = SLOT_RANGE_CODE;
      default:          lk.hit  = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

//--- rtl/measure_word.sv
// One read-only measurement word, loaded only by the control algorithm
`timescale 1ns/1ps
`default_nettype none
module measure_word #(
  parameter int               WIDTH       = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] MAX_VALUE   = '1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Algorithm update
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  // Held word
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] word_reg;
  logic [WIDTH-1:0] word_next;

  // ----------------------------------------------------------------------------
  // Next value; an out-of-range code is dropped so the field never shows a
  // meaning that the encoding does not define
  // ----------------------------------------------------------------------------
  always_comb begin
    word_next = word_reg;
    if (load && (value <= MAX_VALUE)) begin
      word_next = value;
    end
  end

  // Register, cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_reg <= RESET_VALUE;
    end else begin
      word_reg <= word_next;
    end
  end

  assign q = word_reg;

endmodule
`default_nettype wire

//--- rtl/motor_measurement_readback_regs.sv
// Motor measurement readback register bank with an AXI4-Lite slave port
//
// Contract
// (R1) Rotor speed from speed pulses is a 32-bit read-only fixed-point word.
// (R2) DC supply current is a 32-bit read-only fixed-point word.
// (R3) Each of three phase currents has its own 32-bit read-only word.
// (R4) Sense gain code: 0 x8, 1 x4, 2 x2, 3 x1 of highest gain.
// (R5) Voltage range code: 0 is 60 V, 1 is 30 V, 2 is 15 V.
// (R6) The 32-bit speed and current words clear to zero at reset.
// (R7) Both 16-bit code words clear to zero at reset.
// (R8) Every field holds its printed reset value and is read only.
// (R9) Host writes are ignored; only algorithm updates change the contents.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module motor_measurement_readback_regs (
  // Clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // AXI4-Lite write address
  input  wire logic [readback_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                        s_axi_awprot,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [readback_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                        s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [readback_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                        s_axi_arprot,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  // AXI4-Lite read data
  output logic      [readback_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // Algorithm measurement updates, one load strobe per word
  input  wire logic [readback_pkg::DATA_W-1:0]   pulse_speed_value,
  input  wire logic                              pulse_speed_load,
  input  wire logic [readback_pkg::DATA_W-1:0]   supply_current_value,
  input  wire logic                              supply_current_load,
  input  wire logic [readback_pkg::DATA_W-1:0]   phase_one_value,
  input  wire logic                              phase_one_load,
  input  wire logic [readback_pkg::DATA_W-1:0]   phase_two_value,
  input  wire logic                              phase_two_load,
  input  wire logic [readback_pkg::DATA_W-1:0]   phase_three_value,
  input  wire logic                              phase_three_load,
  input  wire logic [readback_pkg::CODE_W-1:0]   sense_gain_code_value,
  input  wire logic                              sense_gain_code_load,
  input  wire logic [readback_pkg::CODE_W-1:0]   voltage_range_code_value,
  input  wire logic                              voltage_range_code_load
);
  import readback_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic              slot_load  [NUM_SLOTS];
  logic [DATA_W-1:0] wide_value [NUM_WIDE];
  logic [DATA_W-1:0] slot_q     [NUM_SLOTS];

  // Write channel state
  wr_state_type      wr_state_reg;
  wr_state_type      wr_state_next;
  logic              aw_done_reg;
  logic              aw_done_next;
  logic              w_done_reg;
  logic              w_done_next;
  logic              awready_reg;
  logic              awready_next;
  logic              wready_reg;
  logic              wready_next;
  logic              bvalid_reg;
  logic              bvalid_next;
  logic [1:0]        bresp_reg;
  logic [1:0]        bresp_next;

  // Read channel state
  rd_state_type      rd_state_reg;
  rd_state_type      rd_state_next;
  logic              arready_reg;
  logic              arready_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  logic [1:0]        rresp_reg;
  logic [1:0]        rresp_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  slot_lookup_if wr_lk ();
  slot_lookup_if rd_lk ();

  // ----------------------------------------------------------------------------
  // Address decoders, one per channel so reads and writes never contend
  // ----------------------------------------------------------------------------
  assign wr_lk.addr = s_axi_awaddr;
  assign rd_lk.addr = s_axi_araddr;

  slot_decode u_wr_decode (
    .lk (wr_lk.decoder)
  );

  slot_decode u_rd_decode (
    .lk (rd_lk.decoder)
  );

  // ----------------------------------------------------------------------------
  // Measurement storage
  // ----------------------------------------------------------------------------

  // Gather the algorithm's update strobes; the host bus has no path here
  always_comb begin
    slot_load[SLOT_PULSE_SPEED] = pulse_speed_load;         // R9
    slot_load[SLOT_SUPPLY_CUR]  = supply_current_load;
    slot_load[SLOT_PHASE_ONE]   = phase_one_load;
    slot_load[SLOT_PHASE_TWO]   = phase_two_load;
    slot_load[SLOT_PHASE_THREE] = phase_three_load;
    slot_load[SLOT_GAIN_CODE]   = sense_gain_code_load;
    slot_load[SLOT_RANGE_CODE]  = voltage_range_code_load;
    wide_value[0] = pulse_speed_value;                       // R1
    wide_value[1] = supply_current_value;                    // R2
    wide_value[2] = phase_one_value;                         // R3
    wide_value[3] = phase_two_value;                         // R3
    wide_value[4] = phase_three_value;                       // R3
  end

  // Five full-width fixed-point words, cleared to zero
  for (genvar i = 0; i < NUM_WIDE; i++) begin : g_wide
    measure_word #(
      .WIDTH       (DATA_W),
      .RESET_VALUE (RST_WIDE),                               // R6
      .MAX_VALUE   (32'hFFFF_FFFF)
    ) u_word (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (slot_load[i]),
      .value   (wide_value[i]),
      .q       (slot_q[i])
    );
  end

  // Sense gain code; codes above the x1 setting are not defined
  logic [CODE_W-1:0] gain_code_q;
  measure_word #(
    .WIDTH       (CODE_W),
    .RESET_VALUE (RST_CODE),                                 // R7
    .MAX_VALUE   (GAIN_X1)                                   // R4
  ) u_gain_code (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (slot_load[SLOT_GAIN_CODE]),
    .value   (sense_gain_code_value),
    .q       (gain_code_q)
  );

  // Voltage range code; codes above the 15 V setting are not defined
  logic [CODE_W-1:0] range_code_q;
  measure_word #(
    .WIDTH       (CODE_W),
    .RESET_VALUE (RST_CODE),                                 // R7
    .MAX_VALUE   (RANGE_15V)                                 // R5
  ) u_range_code (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (slot_load[SLOT_RANGE_CODE]),
    .value   (voltage_range_code_value),
    .q       (range_code_q)
  );

  // Code words sit in the low half; upper bits read as zero
  assign slot_q[SLOT_GAIN_CODE]  = {16'h0000, gain_code_q};
  assign slot_q[SLOT_RANGE_CODE] = {16'h0000, range_code_q};

  // ----------------------------------------------------------------------------
  // Write channel: address and data taken in either order, then answered.
  // Nothing is stored, so a read-only word cannot be disturbed by software.
  // ----------------------------------------------------------------------------
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_done_next  = aw_done_reg;
    w_done_next   = w_done_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    case (wr_state_reg)
      WR_COLLECT: begin
        if (s_axi_awvalid && awready_reg) begin
          aw_done_next = 1'b1;
          // Mapped words answer OKAY and keep their value
          bresp_next   = wr_lk.hit ? RESP_OKAY : RESP_DECERR;  // R9
        end
        if (s_axi_wvalid && wready_reg) begin
          w_done_next = 1'b1;
        end
        if (aw_done_next && w_done_next) begin
          wr_state_next = WR_RESP;
          bvalid_next   = 1'b1;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = WR_COLLECT;
          bvalid_next   = 1'b0;
          aw_done_next  = 1'b0;
          w_done_next   = 1'b0;
        end
      end
      default: begin
        wr_state_next = WR_COLLECT;
        aw_done_next  = 1'b0;
        w_done_next   = 1'b0;
        bvalid_next   = 1'b0;
      end
    endcase
    // Ready is withdrawn once a beat is held, so only one write is in flight
    awready_next = (wr_state_next == WR_COLLECT) && !aw_done_next;
    wready_next  = (wr_state_next == WR_COLLECT) && !w_done_next;
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_COLLECT;
      aw_done_reg  <= 1'b0;
      w_done_reg   <= 1'b0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_done_reg  <= aw_done_next;
      w_done_reg   <= w_done_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Read channel: data is latched at the address handshake, so a word the
  // algorithm updates while rvalid waits does not tear the answer
  // ----------------------------------------------------------------------------
  always_comb begin
    rd_state_next = rd_state_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          rd_state_next = RD_DATA;
          rvalid_next   = 1'b1;
          if (rd_lk.hit) begin
            rdata_next = slot_q[rd_lk.slot];                 // R8
            rresp_next = RESP_OKAY;
          end else begin
            rdata_next = RST_WIDE;
            rresp_next = RESP_DECERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_next = RD_IDLE;
          rvalid_next   = 1'b0;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
        rvalid_next   = 1'b0;
      end
    endcase
    arready_next = (rd_state_next == RD_IDLE);
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= RESP_OKAY;
      rdata_reg    <= RST_WIDE;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule
`default_nettype wire

//--- dv/motor_measurement_readback_regs_asserts.sv
// Concurrent checks on the readback bank's AXI4-Lite port
`timescale 1ns/1ps
`default_nettype none
module motor_measurement_readback_regs_asserts (
  // Clock and reset
  input wire logic                            aclk,
  input wire logic                            aresetn,
  // Write channels
  input wire logic                            s_axi_awready,
  input wire logic                            s_axi_wready,
  input wire logic [1:0]                      s_axi_bresp,
  input wire logic                            s_axi_bvalid,
  input wire logic                            s_axi_bready,
  // Read channels
  input wire logic [readback_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [readback_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                      s_axi_rresp,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready
);
  import readback_pkg::*;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic              rd_hit;

  // ------------------------------
  // Address of the read in flight
  // ------------------------------
  always_comb begin
    rd_addr_next = rd_addr_reg;
    if (!aresetn) begin
      rd_addr_next = '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_next = s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    rd_addr_reg <= rd_addr_next;
  end
  // Misaligned addresses must miss
  assign rd_hit = rd_addr_reg inside {ADDR_PULSE_SPEED, ADDR_SUPPLY_CUR, ADDR_PHASE_ONE, ADDR_PHASE_TWO,
                                      ADDR_PHASE_THREE, ADDR_GAIN_CODE, ADDR_RANGE_CODE};

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !s_axi_arready
    && s_axi_rdata == 32'h0000_0000) else $error("outputs not idle after reset");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data moved while stalled");
  chk_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
  chk_gain_code: assert property (s_axi_rvalid && rd_addr_reg == ADDR_GAIN_CODE |->
    s_axi_rresp == RESP_OKAY && s_axi_rdata <= 32'h0000_0003) else $error("gain code out of range");
  chk_range_code: assert property (s_axi_rvalid && rd_addr_reg == ADDR_RANGE_CODE |->
    s_axi_rresp == RESP_OKAY && s_axi_rdata <= 32'h0000_0002) else $error("range code out of range");
  chk_miss_read: assert property (s_axi_rvalid && !rd_hit |-> s_axi_rresp == RESP_DECERR
    && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  chk_write_quiet: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write open during response");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response moved while stalled");
  chk_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready
    && s_axi_wready) else $error("write not reopened");

  // Main scenarios reached
  cov_gain_read: cover property (s_axi_rvalid && s_axi_rready && rd_addr_reg == ADDR_GAIN_CODE);
  cov_miss_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
  cov_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
endmodule
`default_nettype wire

//--- dv/motor_measurement_readback_regs_bench.sv
// Self-checking bench for the motor measurement readback register bank
`timescale 1ns/1ps
`default_nettype none
module motor_measurement_readback_regs_bench;
  import readback_pkg::*;
  localparam logic [ADDR_W-1:0] ADDRS [NUM_SLOTS] = '{ADDR_PULSE_SPEED, ADDR_SUPPLY_CUR, ADDR_PHASE_ONE,
    ADDR_PHASE_TWO, ADDR_PHASE_THREE, ADDR_GAIN_CODE, ADDR_RANGE_CODE};
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic [DATA_W-1:0] val [NUM_SLOTS] = '{default: '0};
  logic              ld [NUM_SLOTS] = '{default: 1'b0};
  logic [DATA_W-1:0] model [NUM_SLOTS];
  logic [1:0]        resp;
  wire               awready, wready, bvalid, arready, rvalid;
  wire [1:0]         bresp, rresp;
  wire [DATA_W-1:0]  rdata;
  int                miscompares = 0;
  int                n_tests = 0;

  // 25 MHz clock
  always #20 aclk = ~aclk;

  motor_measurement_readback_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pulse_speed_value(val[0]), .pulse_speed_load(ld[0]),
    .supply_current_value(val[1]), .supply_current_load(ld[1]),
    .phase_one_value(val[2]), .phase_one_load(ld[2]),
    .phase_two_value(val[3]), .phase_two_load(ld[3]),
    .phase_three_value(val[4]), .phase_three_load(ld[4]),
    .sense_gain_code_value(val[5][CODE_W-1:0]), .sense_gain_code_load(ld[5]),
    .voltage_range_code_value(val[6][CODE_W-1:0]), .voltage_range_code_load(ld[6])
  );

  // ------------------------------
  // Compare, bus and load tasks
  // ------------------------------
  task automatic check32(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t resp got=%h want=%h", $time, got, want);
    end
  endtask

  // Read: AR held until taken, rready until rvalid
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want, input logic [1:0] wresp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check32(rdata, want);
    check_resp(rresp, wresp);
  endtask

  // Write: AW and W offered together, each dropped when taken
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    do begin
      @(posedge aclk);
      if (aw_open && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end while (aw_open || w_open);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  // One-cycle load; out-of-range codes are dropped
  task automatic put(input int i, input logic [DATA_W-1:0] v);
    @(posedge aclk);
    val[i] <= v;
    ld[i] <= 1'b1;
    @(posedge aclk);
    ld[i] <= 1'b0;
    if (!(i == SLOT_GAIN_CODE && v > 32'h3) && !(i == SLOT_RANGE_CODE && v > 32'h2)) begin
      model[i] = v;
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < NUM_SLOTS; i++) begin
      rd_chk(ADDRS[i], model[i], RESP_OKAY);
    end
  endtask

  // Reset for 12 cycles; every word returns to zero
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    model = '{default: '0};
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    do_reset();
    check_all();
    for (int i = 0; i < NUM_WIDE; i++) begin
      put(i, 32'hA5C3_0F10 ^ (32'h0101_0101 << i));
    end
    check_all();
    // Gain codes above 3 and range codes above 2 are dropped
    for (int c = 0; c < 5; c++) begin
      put(SLOT_GAIN_CODE, c);
      rd_chk(ADDR_GAIN_CODE, model[SLOT_GAIN_CODE], RESP_OKAY);
      put(SLOT_RANGE_CODE, c);
      rd_chk(ADDR_RANGE_CODE, model[SLOT_RANGE_CODE], RESP_OKAY);
    end
    for (int i = 0; i < NUM_SLOTS; i++) begin
      axi_write(ADDRS[i], 32'hFFFF_FFFF, resp);
      check_resp(resp, RESP_OKAY);
    end
    check_all();
    axi_write(13'h0004, 32'h1234_5678, resp);
    check_resp(resp, RESP_DECERR);
    rd_chk(13'h0004, 32'h0000_0000, RESP_DECERR);
    rd_chk(ADDR_PULSE_SPEED + 13'h0001, 32'h0000_0000, RESP_DECERR);
    do_reset();
    check_all();
    wrap_up();
  end

  // Watchdog: the tests need under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end
endmodule

bind motor_measurement_readback_regs motor_measurement_readback_regs_asserts chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire
